// >>> core/iwm_edge_det.sv
`timescale 1ns/100ps
module iwm_edge_det
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Pin and selection
  input wire logic pin_in,
  input wire iwm_pkg::iwm_edge_sel_t edge_sel,
  // Result
  output logic wake_pulse
);

  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic rise;
  logic fall;

  // Two stages before any logic reads the pin
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  assign rise = sync2_q & ~prev_q;
  assign fall = ~sync2_q & prev_q;

  always_comb
  begin
    unique case (edge_sel)
      iwm_pkg::IWM_EDGE_NONE: wake_pulse = 1'b0;
      iwm_pkg::IWM_EDGE_RISE: wake_pulse = rise;
      iwm_pkg::IWM_EDGE_FALL: wake_pulse = fall;
      iwm_pkg::IWM_EDGE_ANY: wake_pulse = rise | fall;
    endcase
  end

  AST_NONE_SILENT: assert property (@(posedge core_clk) disable iff (reset)
    edge_sel == iwm_pkg::IWM_EDGE_NONE |-> !wake_pulse)
    else $error("wake raised with edge selection none");

endmodule : iwm_edge_det

// >>> core/iwm_pkg.sv
package iwm_pkg;

  // Edge selection codes for each wake-capable input pin
  typedef enum logic [1:0]
  {
    IWM_EDGE_NONE = 2'h0,
    IWM_EDGE_RISE = 2'h1,
    IWM_EDGE_FALL = 2'h2,
    IWM_EDGE_ANY = 2'h3
  } iwm_edge_sel_t;

  localparam int IWM_NUM_PINS = 3;

  // Configuration word layout: bit 7..0 as seen by the host
  localparam int IWM_CFG_W = 8;
  localparam int IWM_POS_SEL0 = 6;
  localparam int IWM_POS_SEL1 = 4;
  localparam int IWM_POS_SEL2 = 2;
  localparam int IWM_POS_INH1 = 1;
  localparam int IWM_POS_INH0 = 0;
  localparam logic [IWM_CFG_W-1:0] IWM_CFG_RESET = 8'h00;

  typedef struct packed
  {
    iwm_edge_sel_t pin0_wake_edge_sel;
    iwm_edge_sel_t pin1_wake_edge_sel;
    iwm_edge_sel_t pin2_wake_edge_sel;
    logic int_inh_pin1;
    logic int_inh_pin0;
  } iwm_cfg_t;

endpackage : iwm_pkg

// >>> core/iwm_wake_cfg.sv
`timescale 1ns/100ps
module iwm_wake_cfg
(
  // Clock and resets
  input wire logic core_clk,
  input wire logic reset,
  input wire logic por,
  // Host configuration access
  input wire logic cfg_wr,
  input wire logic [iwm_pkg::IWM_CFG_W-1:0] cfg_wdata,
  output logic [iwm_pkg::IWM_CFG_W-1:0] cfg_rdata,
  output iwm_pkg::iwm_cfg_t cfg_q,
  // Input pins
  input wire logic [iwm_pkg::IWM_NUM_PINS-1:0] io_pin,
  // Events
  output logic [iwm_pkg::IWM_NUM_PINS-1:0] wake_event,
  output logic [iwm_pkg::IWM_NUM_PINS-1:0] int_pulse,
  output logic io_group_flag
);

  iwm_pkg::iwm_cfg_t cfg_d;
  logic [iwm_pkg::IWM_NUM_PINS-1:0] wake_raw;
  logic [iwm_pkg::IWM_NUM_PINS-1:0] int_en;
  logic [iwm_pkg::IWM_NUM_PINS-1:0] grp_q;

  function automatic iwm_pkg::iwm_edge_sel_t get_sel(input logic [iwm_pkg::IWM_CFG_W-1:0] w, input int pos);
    get_sel = iwm_pkg::iwm_edge_sel_t'(w[pos +: $bits(iwm_pkg::iwm_edge_sel_t)]);
  endfunction : get_sel

  always_comb
  begin
    cfg_d = cfg_q;
    if (cfg_wr)
    begin
      cfg_d.pin0_wake_edge_sel = get_sel(cfg_wdata, iwm_pkg::IWM_POS_SEL0);
      cfg_d.pin1_wake_edge_sel = get_sel(cfg_wdata, iwm_pkg::IWM_POS_SEL1);
      cfg_d.pin2_wake_edge_sel = get_sel(cfg_wdata, iwm_pkg::IWM_POS_SEL2);
      cfg_d.int_inh_pin1 = cfg_wdata[iwm_pkg::IWM_POS_INH1];
      cfg_d.int_inh_pin0 = cfg_wdata[iwm_pkg::IWM_POS_INH0];
    end
  end

  // Only power-on reset clears the settings; plain reset keeps them
  always_ff @(posedge core_clk)
  begin
    if (por)
      cfg_q <= iwm_pkg::iwm_cfg_t'(iwm_pkg::IWM_CFG_RESET);
    else
      cfg_q <= cfg_d;
  end

  assign cfg_rdata = cfg_q;

  // Detectors restart on either reset; a pin already high at release reads as a rise
  iwm_edge_det u_det0
  (
    .core_clk(core_clk),
    .reset(reset | por),
    .pin_in(io_pin[0]),
    .edge_sel(cfg_q.pin0_wake_edge_sel),
    .wake_pulse(wake_raw[0])
  );

  iwm_edge_det u_det1
  (
    .core_clk(core_clk),
    .reset(reset | por),
    .pin_in(io_pin[1]),
    .edge_sel(cfg_q.pin1_wake_edge_sel),
    .wake_pulse(wake_raw[1])
  );

  iwm_edge_det u_det2
  (
    .core_clk(core_clk),
    .reset(reset | por),
    .pin_in(io_pin[2]),
    .edge_sel(cfg_q.pin2_wake_edge_sel),
    .wake_pulse(wake_raw[2])
  );

  // Pin two has no inhibit of its own
  assign int_en = {1'b1, ~cfg_q.int_inh_pin1, ~cfg_q.int_inh_pin0};

  always_ff @(posedge core_clk)
  begin
    if (reset | por)
    begin
      wake_event <= '0;
      int_pulse <= '0;
    end
    else
    begin
      wake_event <= wake_raw;
      int_pulse <= wake_raw & int_en;
    end
  end

  // Group flag is a sticky record of every event, masked at the output by the current inhibits; cleared by reset
  always_ff @(posedge core_clk)
  begin
    if (reset | por)
      grp_q <= '0;
    else
      grp_q <= grp_q | wake_raw;
  end

  assign io_group_flag = |(grp_q & int_en);

  AST_INH1_PULSE: assert property (@(posedge core_clk) disable iff (reset | por)
    cfg_q.int_inh_pin1 && $stable(cfg_q.int_inh_pin1) |-> !int_pulse[1])
    else $error("pin one pulse while inhibited");

  AST_INH0_PULSE: assert property (@(posedge core_clk) disable iff (reset | por)
    cfg_q.int_inh_pin0 && $stable(cfg_q.int_inh_pin0) |-> !int_pulse[0])
    else $error("pin zero pulse while inhibited");

  AST_PULSE_PASS: assert property (@(posedge core_clk) disable iff (reset | por)
    wake_raw[1] && !cfg_q.int_inh_pin1 |=> int_pulse[1])
    else $error("unmasked pin one event lost");

  AST_PULSE_PASS0: assert property (@(posedge core_clk) disable iff (reset | por)
    wake_raw[0] && !cfg_q.int_inh_pin0 |=> int_pulse[0])
    else $error("unmasked pin zero event lost");

  AST_PIN2_PASS: assert property (@(posedge core_clk) disable iff (reset | por)
    wake_raw[2] |=> int_pulse[2])
    else $error("pin two event lost");

  AST_GRP_MASK: assert property (@(posedge core_clk) disable iff (reset | por)
    cfg_q.int_inh_pin1 && cfg_q.int_inh_pin0 && !grp_q[2] |-> !io_group_flag)
    else $error("group flag includes inhibited pins");

  AST_GRP_SET: assert property (@(posedge core_clk) disable iff (reset | por)
    wake_raw[2] |=> io_group_flag)
    else $error("group flag missed an unmasked event");

  AST_WRITE_SEL1: assert property (@(posedge core_clk) disable iff (por)
    cfg_wr |=> cfg_q.pin1_wake_edge_sel == get_sel($past(cfg_wdata), iwm_pkg::IWM_POS_SEL1))
    else $error("pin one selection not stored");

  AST_WRITE_SEL2: assert property (@(posedge core_clk) disable iff (por)
    cfg_wr |=> cfg_q.pin2_wake_edge_sel == get_sel($past(cfg_wdata), iwm_pkg::IWM_POS_SEL2))
    else $error("pin two selection not stored");

  AST_WRITE_SEL0: assert property (@(posedge core_clk) disable iff (por)
    cfg_wr |=> cfg_q.pin0_wake_edge_sel == get_sel($past(cfg_wdata), iwm_pkg::IWM_POS_SEL0))
    else $error("pin zero selection not stored");

  AST_WRITE_INH1: assert property (@(posedge core_clk) disable iff (por)
    cfg_wr |=> cfg_q.int_inh_pin1 == $past(cfg_wdata[iwm_pkg::IWM_POS_INH1]))
    else $error("pin one inhibit not stored");

  AST_WRITE_INH0: assert property (@(posedge core_clk) disable iff (por)
    cfg_wr |=> cfg_q.int_inh_pin0 == $past(cfg_wdata[iwm_pkg::IWM_POS_INH0]))
    else $error("pin zero inhibit not stored");

  AST_KEEP_ON_RESET: assert property (@(posedge core_clk) disable iff (por)
    reset && !cfg_wr |=> $stable(cfg_q))
    else $error("settings lost on plain reset");

  AST_POR_CLEAR: assert property (@(posedge core_clk)
    por |=> cfg_q == iwm_pkg::iwm_cfg_t'(iwm_pkg::IWM_CFG_RESET))
    else $error("power-on reset did not clear settings");

  AST_RISE_ONLY: assert property (@(posedge core_clk) disable iff (reset | por)
    wake_raw[1] && cfg_q.pin1_wake_edge_sel == iwm_pkg::IWM_EDGE_RISE |-> u_det1.sync2_q)
    else $error("rise selection woke on a falling edge");

  // Edge shapes at a detector's synchronized sample, oldest sample first
  sequence seq_rise(logic s);
    !s ##1 s;
  endsequence

  sequence seq_fall(logic s);
    s ##1 !s;
  endsequence

  // A selected edge must reach the event register one cycle after the compare
  AST_RISE_EVENT0: assert property (@(posedge core_clk) disable iff (reset | por)
    seq_rise(u_det0.sync2_q) ##0
    cfg_q.pin0_wake_edge_sel inside {iwm_pkg::IWM_EDGE_RISE, iwm_pkg::IWM_EDGE_ANY} |=> wake_event[0])
    else $error("pin zero rising edge missed");

  AST_FALL_EVENT0: assert property (@(posedge core_clk) disable iff (reset | por)
    seq_fall(u_det0.sync2_q) ##0
    cfg_q.pin0_wake_edge_sel inside {iwm_pkg::IWM_EDGE_FALL, iwm_pkg::IWM_EDGE_ANY} |=> wake_event[0])
    else $error("pin zero falling edge missed");

  AST_RISE_EVENT1: assert property (@(posedge core_clk) disable iff (reset | por)
    seq_rise(u_det1.sync2_q) ##0
    cfg_q.pin1_wake_edge_sel inside {iwm_pkg::IWM_EDGE_RISE, iwm_pkg::IWM_EDGE_ANY} |=> wake_event[1])
    else $error("pin one rising edge missed");

  AST_FALL_EVENT1: assert property (@(posedge core_clk) disable iff (reset | por)
    seq_fall(u_det1.sync2_q) ##0
    cfg_q.pin1_wake_edge_sel inside {iwm_pkg::IWM_EDGE_FALL, iwm_pkg::IWM_EDGE_ANY} |=> wake_event[1])
    else $error("pin one falling edge missed");

  AST_FALL_SILENT1: assert property (@(posedge core_clk) disable iff (reset | por)
    seq_fall(u_det1.sync2_q) ##0
    cfg_q.pin1_wake_edge_sel == iwm_pkg::IWM_EDGE_RISE |=> !wake_event[1])
    else $error("pin one rise selection woke on a fall");

  AST_RISE_EVENT2: assert property (@(posedge core_clk) disable iff (reset | por)
    seq_rise(u_det2.sync2_q) ##0
    cfg_q.pin2_wake_edge_sel inside {iwm_pkg::IWM_EDGE_RISE, iwm_pkg::IWM_EDGE_ANY} |=> wake_event[2])
    else $error("pin two rising edge missed");

  AST_FALL_EVENT2: assert property (@(posedge core_clk) disable iff (reset | por)
    seq_fall(u_det2.sync2_q) ##0
    cfg_q.pin2_wake_edge_sel inside {iwm_pkg::IWM_EDGE_FALL, iwm_pkg::IWM_EDGE_ANY} |=> wake_event[2])
    else $error("pin two falling edge missed");

  AST_NO_WAKE2: assert property (@(posedge core_clk) disable iff (reset | por)
    cfg_q.pin2_wake_edge_sel == iwm_pkg::IWM_EDGE_NONE |=> !wake_event[2])
    else $error("pin two woke with edge selection none");

endmodule : iwm_wake_cfg

// >>> tb/iwm_pin_model.sv
`timescale 1ns/100ps
module iwm_pin_model
(
  // Clock
  input wire logic core_clk,
  // Levels asked for and levels driven
  input wire logic [2:0] level_req,
  output logic [2:0] io_pin
);
  // Pins move one edge after the request, like a slow external source
  always_ff @(posedge core_clk)
  begin
    io_pin <= level_req;
  end
endmodule : iwm_pin_model

// >>> tb/tb_io_wakeup_irq_mask_config.sv
`timescale 1ns/100ps
module tb_io_wakeup_irq_mask_config;
  logic core_clk, reset, por, cfg_wr, io_group_flag;
  logic [7:0] cfg_wdata, cfg_rdata;
  logic [2:0] lvl, io_pin, wake_event, int_pulse;
  iwm_pkg::iwm_cfg_t cfg_q;
  int fails, n_compared;
  iwm_pin_model iwm_pin_model_inst (.core_clk(core_clk), .level_req(lvl), .io_pin(io_pin));
  iwm_wake_cfg iwm_wake_cfg_inst (.core_clk(core_clk), .reset(reset), .por(por), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_q(cfg_q), .io_pin(io_pin),
    .wake_event(wake_event), .int_pulse(int_pulse), .io_group_flag(io_group_flag));
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic wr(logic [7:0] v);
    @(posedge core_clk);
    cfg_wr <= 1'b1;
    cfg_wdata <= v;
    @(posedge core_clk);
    cfg_wr <= 1'b0;
    #1 cmp("cfg_rdata", v, cfg_rdata);
    cmp("cfg_q", v, cfg_q);
  endtask : wr
  // Counts pulses over a fixed window longer than the pin-to-event path
  task automatic pin_to(int p, logic v, logic ew, logic ei);
    logic [7:0] sw, si;
    sw = 8'h00;
    si = 8'h00;
    @(posedge core_clk);
    lvl[p] <= v;
    repeat (8)
    begin
      @(posedge core_clk);
      #1;
      sw += 8'(wake_event[p]);
      si += 8'(int_pulse[p]);
    end
    cmp("wake_event", 8'(ew), sw);
    cmp("int_pulse", 8'(ei), si);
  endtask : pin_to
  task automatic pulse(logic r, logic p);
    @(posedge core_clk);
    reset <= r;
    por <= p;
    @(posedge core_clk);
    reset <= 1'b0;
    por <= 1'b0;
    #1;
  endtask : pulse
  task automatic report_and_stop();
    if (fails == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    reset = 1'b1;
    por = 1'b1;
    cfg_wr = 1'b0;
    cfg_wdata = 8'h00;
    lvl = 3'h0;
    fails = 0;
    n_compared = 0;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    por <= 1'b0;
    #1 cmp("cfg_rdata", 8'h00, cfg_rdata);
    // Same code in all three fields, every code in turn
    for (int s = 0; s < 4; s++)
    begin
      wr(8'(s * 8'h54));
      for (int p = 0; p < 3; p++)
      begin
        pin_to(p, 1'b1, s[0], s[0]);
        pin_to(p, 1'b0, s[1], s[1]);
      end
    end
    // Different codes per field catch swapped field positions
    wr(8'h1C);
    pin_to(0, 1'b1, 1'b0, 1'b0);
    pin_to(1, 1'b1, 1'b1, 1'b1);
    pin_to(2, 1'b1, 1'b1, 1'b1);
    pin_to(0, 1'b0, 1'b0, 1'b0);
    pin_to(1, 1'b0, 1'b0, 1'b0);
    pin_to(2, 1'b0, 1'b1, 1'b1);
    cmp("io_group_flag", 8'h01, 8'(io_group_flag));
    pulse(1'b1, 1'b0);
    cmp("cfg_rdata", 8'h1C, cfg_rdata);
    cmp("io_group_flag", 8'h00, 8'(io_group_flag));
    // A write in the same cycle as plain reset still lands
    @(posedge core_clk);
    reset <= 1'b1;
    cfg_wr <= 1'b1;
    cfg_wdata <= 8'h54;
    @(posedge core_clk);
    reset <= 1'b0;
    cfg_wr <= 1'b0;
    #1 cmp("cfg_rdata", 8'h54, cfg_rdata);
    wr(8'hFF);
    pin_to(0, 1'b1, 1'b1, 1'b0);
    pin_to(1, 1'b1, 1'b1, 1'b0);
    cmp("io_group_flag", 8'h00, 8'(io_group_flag));
    pin_to(2, 1'b1, 1'b1, 1'b1);
    cmp("io_group_flag", 8'h01, 8'(io_group_flag));
    pulse(1'b0, 1'b1);
    cmp("cfg_rdata", 8'h00, cfg_rdata);
    report_and_stop();
  end
endmodule : tb_io_wakeup_irq_mask_config
